// ===== pdo_pkg.sv
// Constants, register map and mode codes of the power-down and auxiliary clock divider block.
package pdo_pkg;
  localparam logic [31:0] ADDR_AUX_DIV     = 32'h01b7c124;
  localparam logic [31:0] ADDR_CPU_CTRL    = 32'h01b7c128;
  localparam logic [31:0] ADDR_MODE_STATUS = 32'h01b7c12c;

  localparam int RATIO_W      = 5;
  localparam int RATIO_LSB    = 0;
  localparam int AUX_EN_BIT   = 15;
  localparam int PD_FIELD_W   = 6;
  localparam int PD_FIELD_LSB = 10;

  localparam logic [4:0] RATIO_RESET    = 5'h07;
  localparam logic       AUX_EN_RESET   = 1'b1;
  localparam logic [5:0] PD_FIELD_RESET = 6'h00;

  localparam logic [5:0] PD_NONE          = 6'h00;
  localparam logic [5:0] PD_SLEEP_ENABLED = 6'h09;
  localparam logic [5:0] PD_SLEEP_ANY     = 6'h11;
  localparam logic [5:0] PD_CLOCK_STOP    = 6'h1a;
  localparam logic [5:0] PD_DEEP_STOP     = 6'h1c;

  // Countdown loaded by the field write; the mode takes effect one cycle after this many cycles; must stay at or below the limit.
  localparam logic [3:0] PD_APPLY_CYC = 4'h4;
  localparam logic [3:0] PD_APPLY_MAX = 4'h9;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [4:0] {
    ST_RUN       = 5'h01,
    ST_SLEEP_EN  = 5'h02,
    ST_SLEEP_ANY = 5'h04,
    ST_CLK_STOP  = 5'h08,
    ST_DEEP_STOP = 5'h10
  } pdo_mode_t;
endpackage

// ===== pdo_clk_div.sv
// Glitch-free integer divider producing the auxiliary clock from the reference clock.
`timescale 1ns/100ps
`default_nettype none
module pdo_clk_div #(
  parameter int W = 5
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         enable,
  input  wire logic [W-1:0] ratio,
  output var  logic         clk_out
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic [W-1:0] live_r;
  logic [W-1:0] live_nxt;
  logic         out_r;
  logic         out_nxt;
  logic [W:0]   half;

  // A new ratio is taken only at a period boundary so no short pulse appears.
  always_comb begin
    cnt_nxt  = cnt_r;
    live_nxt = live_r;
    half     = '0;
    out_nxt  = 1'b0;
    if (!enable) begin
      cnt_nxt  = '0;
      live_nxt = ratio;
      out_nxt  = 1'b0;
    end else begin
      if (cnt_r >= live_r) begin
        cnt_nxt  = '0;
        live_nxt = ratio;
      end else begin
        cnt_nxt = W'(cnt_r + 1'b1);
      end
      half    = (W+1)'(({1'b0, live_nxt} + 2'd2) >> 1);
      out_nxt = ({1'b0, cnt_nxt} < half);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r  <= '0;
      live_r <= '0;
      out_r  <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      live_r <= live_nxt;
      out_r  <= out_nxt;
    end
  end

  assign clk_out = out_r;

  a_div_hold_low: assert property (@(posedge hclk) disable iff (!hresetn)
    !enable |=> !clk_out) else $error("aux clock not held low while disabled");
  a_div_cnt_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    cnt_r <= live_r) else $error("divider count beyond ratio");
endmodule
`default_nettype wire

// ===== pdo_power_ctrl.sv
// Power-down mode control, clock gating and auxiliary divider registers behind an AHB-Lite slave.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Aux clock is the reference divided by the ratio field plus one; reset selects divide-by-8.
// - Bit 15 of the divider register enables the divider and resets to one.
// - The auxiliary clock is made from the reference clock, never from the PLL output.
// - Bits 31:16 and 14:5 of the divider register read zero and ignore writes.
// - Light sleep gates the CPU clock; clock-stop with the PLL in use gates the CPU, reference, DMA and auxiliary clocks.
// - Clock-stop modes stop clocks only by stopping the PLL and do nothing while it is bypassed.
// - The mode and its wake-up method come from bits 15:10 of the CPU control register.
// - Codes select no power-down, two light sleeps or two clock-stop modes; others are reserved.
// - Clock-stop modes end only by device reset, never by an interrupt.
// - Light sleep stops the CPU clock, keeps interrupt logic alive and lets DMA run.
// - A written mode takes effect no more than nine cycles after the write.
module pdo_power_ctrl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        irq_enabled_in,
  input  wire logic        irq_any_in,
  input  wire logic        pll_mode_select,
  output var  logic        aux_clock_out,
  output var  logic        ref_clock_en,
  output var  logic        cpu_clock_en,
  output var  logic        dma_clock_en,
  output var  logic        pll_clock_stop,
  output var  logic        deep_stop_active
);
  logic                  take;
  logic                  wr_pend_r;
  logic                  wr_pend_nxt;
  logic [31:0]           wr_addr_r;
  logic [31:0]           wr_addr_nxt;
  logic [31:0]           hrdata_r;
  logic [31:0]           hrdata_nxt;
  logic                  hreadyout_r;
  logic                  hresp_r;
  logic [4:0]            ratio_r;
  logic [4:0]            ratio_nxt;
  logic                  aux_en_r;
  logic                  aux_en_nxt;
  logic [5:0]            pd_field_r;
  logic [5:0]            pd_field_nxt;
  logic [3:0]            apply_r;
  logic [3:0]            apply_nxt;
  pdo_pkg::pdo_mode_t    mode_r;
  pdo_pkg::pdo_mode_t    mode_nxt;
  logic                  wake;
  logic                  stop;
  logic                  ref_en_r;
  logic                  ref_en_nxt;
  logic                  cpu_en_r;
  logic                  cpu_en_nxt;
  logic                  dma_en_r;
  logic                  dma_en_nxt;
  logic                  pll_stop_r;
  logic                  pll_stop_nxt;
  logic                  deep_r;
  logic                  deep_nxt;

  function automatic pdo_pkg::pdo_mode_t decode(input logic [5:0] code);
    case (code)
      pdo_pkg::PD_SLEEP_ENABLED: decode = pdo_pkg::ST_SLEEP_EN;
      pdo_pkg::PD_SLEEP_ANY:     decode = pdo_pkg::ST_SLEEP_ANY;
      pdo_pkg::PD_CLOCK_STOP:    decode = pdo_pkg::ST_CLK_STOP;
      pdo_pkg::PD_DEEP_STOP:     decode = pdo_pkg::ST_DEEP_STOP;
      default:                   decode = pdo_pkg::ST_RUN;
    endcase
  endfunction

  assign take = hsel & htrans[1] & hready & (hsize == pdo_pkg::HSIZE_WORD);

  // Mode sequencing: the stored field is applied once the apply countdown reaches one.
  always_comb begin
    mode_nxt = mode_r;
    wake     = 1'b0;
    case (mode_r)
      pdo_pkg::ST_RUN: begin
        if (apply_r == 4'h1) begin
          mode_nxt = decode(pd_field_r);
        end
      end
      pdo_pkg::ST_SLEEP_EN: begin
        if (irq_enabled_in) begin
          wake = 1'b1;
        end else if (apply_r == 4'h1) begin
          mode_nxt = decode(pd_field_r);
        end
      end
      pdo_pkg::ST_SLEEP_ANY: begin
        if (irq_enabled_in | irq_any_in) begin
          wake = 1'b1;
        end else if (apply_r == 4'h1) begin
          mode_nxt = decode(pd_field_r);
        end
      end
      pdo_pkg::ST_CLK_STOP: mode_nxt = pdo_pkg::ST_CLK_STOP;
      pdo_pkg::ST_DEEP_STOP: mode_nxt = pdo_pkg::ST_DEEP_STOP;
      default: mode_nxt = pdo_pkg::ST_RUN;
    endcase
    if (wake) begin
      mode_nxt = pdo_pkg::ST_RUN;
    end
  end

  // Registers; a wake clears the field, but a write in the same cycle overrides it.
  always_comb begin
    ratio_nxt    = ratio_r;
    aux_en_nxt   = aux_en_r;
    pd_field_nxt = pd_field_r;
    apply_nxt    = (apply_r != 4'h0) ? 4'(apply_r - 4'h1) : 4'h0;
    if (wake) begin
      pd_field_nxt = pdo_pkg::PD_NONE;
    end
    if (wr_pend_r) begin
      case (wr_addr_r)
        pdo_pkg::ADDR_AUX_DIV: begin
          ratio_nxt  = hwdata[pdo_pkg::RATIO_LSB +: pdo_pkg::RATIO_W];
          aux_en_nxt = hwdata[pdo_pkg::AUX_EN_BIT];
        end
        pdo_pkg::ADDR_CPU_CTRL: begin
          pd_field_nxt = hwdata[pdo_pkg::PD_FIELD_LSB +: pdo_pkg::PD_FIELD_W];
          apply_nxt    = pdo_pkg::PD_APPLY_CYC;
        end
        default: begin
        end
      endcase
    end
  end

  // Bus slave: zero wait states; reads return the values as of the end of this cycle.
  always_comb begin
    wr_pend_nxt = take & hwrite;
    wr_addr_nxt = take ? haddr : wr_addr_r;
    hrdata_nxt  = hrdata_r;
    if (take & !hwrite) begin
      case (haddr)
        pdo_pkg::ADDR_AUX_DIV:
          hrdata_nxt = {16'h0000, aux_en_nxt, 10'h000, ratio_nxt};
        pdo_pkg::ADDR_CPU_CTRL:
          hrdata_nxt = {16'h0000, pd_field_nxt, 10'h000};
        pdo_pkg::ADDR_MODE_STATUS:
          hrdata_nxt = {27'h0000000, mode_nxt};
        default:
          hrdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Clock gating: clock-stop acts only through the PLL, so a bypassed PLL keeps all running.
  always_comb begin
    stop         = (mode_r == pdo_pkg::ST_CLK_STOP) | (mode_r == pdo_pkg::ST_DEEP_STOP);
    pll_stop_nxt = stop & pll_mode_select;
    ref_en_nxt   = !(stop & pll_mode_select);
    dma_en_nxt   = !(stop & pll_mode_select);
    cpu_en_nxt   = (mode_r == pdo_pkg::ST_RUN) | (stop & !pll_mode_select);
    deep_nxt     = (mode_r == pdo_pkg::ST_DEEP_STOP) & pll_mode_select;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 32'h00000000;
      hrdata_r    <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      ratio_r     <= pdo_pkg::RATIO_RESET;
      aux_en_r    <= pdo_pkg::AUX_EN_RESET;
      pd_field_r  <= pdo_pkg::PD_FIELD_RESET;
      apply_r     <= 4'h0;
      mode_r      <= pdo_pkg::ST_RUN;
      ref_en_r    <= 1'b1;
      cpu_en_r    <= 1'b1;
      dma_en_r    <= 1'b1;
      pll_stop_r  <= 1'b0;
      deep_r      <= 1'b0;
    end else begin
      wr_pend_r   <= wr_pend_nxt;
      wr_addr_r   <= wr_addr_nxt;
      hrdata_r    <= hrdata_nxt;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      ratio_r     <= ratio_nxt;
      aux_en_r    <= aux_en_nxt;
      pd_field_r  <= pd_field_nxt;
      apply_r     <= apply_nxt;
      mode_r      <= mode_nxt;
      ref_en_r    <= ref_en_nxt;
      cpu_en_r    <= cpu_en_nxt;
      dma_en_r    <= dma_en_nxt;
      pll_stop_r  <= pll_stop_nxt;
      deep_r      <= deep_nxt;
    end
  end

  // The divider runs on the reference clock itself and stops with it.
  pdo_clk_div #(
    .W (pdo_pkg::RATIO_W)
  ) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (aux_en_r & ref_en_r),
    .ratio   (ratio_r),
    .clk_out (aux_clock_out)
  );

  assign hreadyout        = hreadyout_r;
  assign hresp            = hresp_r;
  assign hrdata           = hrdata_r;
  assign ref_clock_en     = ref_en_r;
  assign cpu_clock_en     = cpu_en_r;
  assign dma_clock_en     = dma_en_r;
  assign pll_clock_stop   = pll_stop_r;
  assign deep_stop_active = deep_r;

  a_div_read_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && haddr == pdo_pkg::ADDR_AUX_DIV)
    |=> (hrdata[31:16] == 16'h0000 && hrdata[14:5] == 10'h000))
    else $error("reserved divider bits read nonzero");
  a_stop_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_r == pdo_pkg::ST_CLK_STOP || mode_r == pdo_pkg::ST_DEEP_STOP)
    |=> $stable(mode_r)) else $error("clock-stop mode left without reset");
  a_stop_gates_ref: assert property (@(posedge hclk) disable iff (!hresetn)
    (stop && pll_mode_select) |=> (!ref_clock_en && pll_clock_stop && !dma_clock_en))
    else $error("clock-stop did not stop the PLL path");
  a_bypass_runs: assert property (@(posedge hclk) disable iff (!hresetn)
    (stop && !pll_mode_select) |=> (ref_clock_en && cpu_clock_en && !pll_clock_stop))
    else $error("clocks stopped while PLL bypassed");
  a_sleep_gating: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_r == pdo_pkg::ST_SLEEP_EN || mode_r == pdo_pkg::ST_SLEEP_ANY)
    |=> (!cpu_clock_en && dma_clock_en)) else $error("light sleep gating wrong");
  a_stop_apply: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && wr_addr_r == pdo_pkg::ADDR_CPU_CTRL && hwdata[15:10] == 6'h1a
     && mode_r == pdo_pkg::ST_RUN)
    |-> ##[1:9] (mode_r == pdo_pkg::ST_CLK_STOP)) else $error("mode not applied in nine");
  a_sleep_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_r == pdo_pkg::ST_SLEEP_ANY && irq_any_in && !wr_pend_r)
    |=> (mode_r == pdo_pkg::ST_RUN && pd_field_r == 6'h00)) else $error("sleep wake missed");
  a_field_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && haddr == pdo_pkg::ADDR_CPU_CTRL)
    |=> (hrdata[15:10] == $past(pd_field_nxt) && hrdata[9:0] == 10'h000))
    else $error("power-down field readback wrong");
endmodule
`default_nettype wire

// ===== pdo_far_model.sv
// Behavioural model of the PLL control and wake sources facing the power-down block.
`timescale 1ns/100ps
`default_nettype none
module pdo_far_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pll_enable_req,
  input  wire logic wake_en_req,
  input  wire logic wake_any_req,
  input  wire logic pll_clock_stop,
  input  wire logic pll_power_down_bit,
  output var  logic pll_mode_select,
  output var  logic irq_enabled_in,
  output var  logic irq_any_in,
  output var  logic pll_running
);
  // The PLL comes out of reset in bypass and is only used once software enables it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_mode_select <= 1'b0;
      irq_enabled_in  <= 1'b0;
      irq_any_in      <= 1'b0;
      pll_running     <= 1'b0;
    end else begin
      pll_mode_select <= pll_enable_req;
      irq_enabled_in  <= wake_en_req;
      irq_any_in      <= wake_any_req;
      pll_running     <= pll_mode_select & ~pll_clock_stop & ~pll_power_down_bit;
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking testbench for the power-down control and auxiliary clock divider.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        pll_req = 1'b0;
  logic        we_req = 1'b0;
  logic        wa_req = 1'b0;
  logic        pdn_req = 1'b0;
  logic [2:0]  sz = 3'h2;
  wire         hreadyout, hresp, aux, ref_en, cpu_en, dma_en, pstop, deep;
  wire         pll_sel, irq_en, irq_any, pll_run;
  wire  [31:0] hrdata;
  int          failures = 0;
  int          total_checks = 0;
  int          c;
  int          r[3] = '{0, 2, 31};
  int          n[3] = '{30, 30, 64};
  int          e[3] = '{30, 20, 32};
  localparam logic [31:0] A_DIV = pdo_pkg::ADDR_AUX_DIV;
  localparam logic [31:0] A_CTL = pdo_pkg::ADDR_CPU_CTRL;
  localparam logic [31:0] A_ST  = pdo_pkg::ADDR_MODE_STATUS;

  always #20 hclk = ~hclk;

  pdo_power_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_enabled_in(irq_en),
    .irq_any_in(irq_any), .pll_mode_select(pll_sel), .aux_clock_out(aux),
    .ref_clock_en(ref_en), .cpu_clock_en(cpu_en), .dma_clock_en(dma_en),
    .pll_clock_stop(pstop), .deep_stop_active(deep));

  pdo_far_model far (.hclk(hclk), .hresetn(hresetn), .pll_enable_req(pll_req),
    .wake_en_req(we_req), .wake_any_req(wa_req), .pll_clock_stop(pstop),
    .pll_power_down_bit(pdn_req),
    .pll_mode_select(pll_sel), .irq_enabled_in(irq_en), .irq_any_in(irq_any),
    .pll_running(pll_run));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
    chk("response", {31'h0, hresp}, 32'h0);
  endtask

  task automatic auxcnt(input int n);
    c = 0;
    repeat (n) begin
      @(negedge hclk);
      if (aux === 1'b1) c++;
    end
  endtask

  task automatic settle();
    repeat (9) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic wake(input logic en);
    @(posedge hclk);
    we_req <= en;
    wa_req <= ~en;
    @(posedge hclk);
    we_req <= 1'b0;
    wa_req <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  task automatic rst();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd("divider reg", A_DIV, 32'h00008007);
    rd("control reg", A_CTL, 32'h0);
    rd("mode status", A_ST, 32'h1);
    rd("unmapped", 32'h01b7c130, 32'h0);
    wr(A_DIV, 32'hffffffff);
    rd("divider reg", A_DIV, 32'h0000801f);
    sz = 3'h0;
    wr(A_DIV, 32'h00008000);
    sz = pdo_pkg::HSIZE_WORD;
    rd("byte write", A_DIV, 32'h0000801f);
    for (int i = 0; i < 3; i++) begin
      wr(A_DIV, 32'h00008000 | r[i]);
      repeat (40) @(posedge hclk);
      auxcnt(n[i]);
      chk("aux high", c, e[i]);
    end
    wr(A_DIV, 32'h00000002);
    repeat (4) @(posedge hclk);
    auxcnt(30);
    chk("aux disabled", c, 32'h0);
    wr(A_DIV, 32'h00008002);
    repeat (4) @(posedge hclk);
    auxcnt(30);
    chk("aux restart", c, 32'd20);
    $display("divider test done");
    wr(A_CTL, 32'h00002400);
    settle();
    chk("cpu clock", cpu_en, 1'b0);
    chk("dma clock", dma_en, 1'b1);
    chk("ref clock", ref_en, 1'b1);
    rd("mode status", A_ST, 32'h2);
    wake(1'b0);
    rd("mode status", A_ST, 32'h2);
    wake(1'b1);
    rd("mode status", A_ST, 32'h1);
    wr(A_CTL, 32'h00004400);
    settle();
    rd("mode status", A_ST, 32'h4);
    wake(1'b0);
    rd("mode status", A_ST, 32'h1);
    wr(A_CTL, 32'h00000c00);
    settle();
    rd("reserved code", A_ST, 32'h1);
    $display("sleep test done");
    wr(A_CTL, 32'h00006800);
    settle();
    rd("mode status", A_ST, 32'h8);
    chk("bypass stop", {pstop, cpu_en, dma_en}, 3'b011);
    wake(1'b1);
    rd("mode status", A_ST, 32'h8);
    rst();
    rd("mode status", A_ST, 32'h1);
    pll_req <= 1'b1;
    repeat (3) @(posedge hclk);
    wr(A_CTL, 32'h00007000);
    settle();
    chk("deep stop", {deep, pstop, ref_en, dma_en, cpu_en}, 5'b11000);
    chk("pll running", pll_run, 1'b0);
    auxcnt(16);
    chk("aux stopped", c, 32'h0);
    wake(1'b1);
    chk("deep held", {deep, ref_en}, 2'b10);
    rst();
    repeat (3) @(posedge hclk);
    pdn_req <= 1'b1;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk("pll power down", {pll_run, deep, cpu_en}, 3'b001);
    @(posedge hclk);
    pdn_req <= 1'b0;
    wr(A_CTL, 32'h00006800);
    settle();
    chk("clock stop", {deep, pstop, cpu_en}, 3'b010);
    rst();
    @(negedge hclk);
    chk("after reset", {pstop, ref_en, cpu_en}, 3'b011);
    $display("stop test done");
    summarize();
  end
endmodule
`default_nettype wire
